/* cjsb_exec.sv */
// execution datapath for pc-relative, jump, branch, seal and build operations
`timescale 1ns/1ps
module cjsb_exec
  import cjsb_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // request
  input  wire logic              req_valid,
  input  wire cjsb_op_t          req_op,
  input  wire logic [4:0]        rd_idx,
  input  wire logic [4:0]        rs1_idx,
  input  wire logic [4:0]        rs2_idx,
  input  wire logic [19:0]       imm,
  input  wire logic              instr_short,
  // current pc capability
  input  wire logic              pc_tag,
  input  wire logic [CT_W-1:0]   pc_ct,
  input  wire logic [PERM_W-1:0] pc_perm,
  input  wire logic [RSV_W-1:0]  pc_rsv,
  input  wire logic [XLEN-1:0]   pc_base,
  input  wire logic [XLEN-1:0]   pc_top,
  input  wire logic [XLEN-1:0]   pc_addr,
  // first source capability
  input  wire logic              s1_tag,
  input  wire logic [CT_W-1:0]   s1_ct,
  input  wire logic [PERM_W-1:0] s1_perm,
  input  wire logic [RSV_W-1:0]  s1_rsv,
  input  wire logic [XLEN-1:0]   s1_base,
  input  wire logic [XLEN-1:0]   s1_top,
  input  wire logic [XLEN-1:0]   s1_addr,
  // second source capability
  input  wire logic              s2_tag,
  input  wire logic [CT_W-1:0]   s2_ct,
  input  wire logic [PERM_W-1:0] s2_perm,
  input  wire logic [RSV_W-1:0]  s2_rsv,
  input  wire logic [XLEN-1:0]   s2_base,
  input  wire logic [XLEN-1:0]   s2_top,
  input  wire logic [XLEN-1:0]   s2_addr,
  // destination write
  output logic                   rd_wr,
  output logic                   rd_tag,
  output logic [CT_W-1:0]        rd_ct,
  output logic [PERM_W-1:0]      rd_perm,
  output logic [RSV_W-1:0]       rd_rsv,
  output logic [XLEN-1:0]        rd_base,
  output logic [XLEN-1:0]        rd_top,
  output logic [XLEN-1:0]        rd_addr,
  // next pc
  output logic                   npc_wr,
  output logic                   npc_tag,
  output logic [CT_W-1:0]        npc_ct,
  output logic [PERM_W-1:0]      npc_perm,
  output logic [RSV_W-1:0]       npc_rsv,
  output logic [XLEN-1:0]        npc_base,
  output logic [XLEN-1:0]        npc_top,
  output logic [XLEN-1:0]        npc_addr,
  // status
  output logic                   done,
  output logic                   reserved_enc,
  output logic                   fetch_fault
);

  //////////////////////////////////////////////////////////////////////////////
  // operand assembly

  cjsb_cap_t pc_c;
  cjsb_cap_t s1_c;
  cjsb_cap_t s2_c;

  // pack the flat operand ports into capabilities
  assign pc_c = '{pc_tag, pc_ct, pc_perm, pc_rsv, pc_base, pc_top, pc_addr};
  assign s1_c = '{s1_tag, s1_ct, s1_perm, s1_rsv, s1_base, s1_top, s1_addr};
  assign s2_c = '{s2_tag, s2_ct, s2_perm, s2_rsv, s2_base, s2_top, s2_addr};

  logic [XLEN-1:0] off_upper;
  logic [XLEN-1:0] off_jump;
  logic [XLEN-1:0] off_ind;
  logic [XLEN-1:0] off_br;
  logic [XLEN-1:0] ins_width;

  // immediate forms, all sign-extended
  assign off_upper = XLEN'(signed'(imm)) << UPPER_SHIFT;
  assign off_jump  = XLEN'(signed'({imm, 1'b0}));
  assign off_ind   = XLEN'(signed'(imm[11:0]));
  assign off_br    = XLEN'(signed'({imm[11:0], 1'b0}));
  assign ins_width = instr_short ? WIDTH_SHORT : WIDTH_FULL;

  //////////////////////////////////////////////////////////////////////////////
  // result computation

  cjsb_cap_t rd_nxt;
  cjsb_cap_t npc_nxt;
  logic      rd_wr_nxt;
  logic      npc_wr_nxt;
  logic      done_nxt;
  logic      rsv_nxt;
  logic      ff_nxt;

  // one operation per request, chosen by the decoded op
  always_comb begin
    cjsb_cap_t t;
    cjsb_cap_t lk;
    logic      ok;
    t          = CAP_NULL;
    lk         = CAP_NULL;
    ok         = 1'b0;
    rd_nxt     = CAP_NULL;
    npc_nxt    = CAP_NULL;
    rd_wr_nxt  = 1'b0;
    npc_wr_nxt = 1'b0;
    rsv_nxt    = 1'b0;
    ff_nxt     = 1'b0;
    done_nxt   = req_valid;
    if (req_valid) begin
      case (req_op)
        CJSB_OP_UPPER_PC: begin
          rd_nxt    = cjsb_addr_set(pc_c, pc_c.addr + off_upper);
          rd_wr_nxt = rd_idx != REG_ZERO;
        end
        CJSB_OP_JUMP_DIR: begin
          npc_nxt    = cjsb_addr_set(pc_c, pc_c.addr + off_jump);
          npc_wr_nxt = 1'b1;
          lk         = cjsb_addr_set(pc_c, pc_c.addr + ins_width);
          lk.ct      = CT_ENTRY;
          rd_nxt     = lk;
          rd_wr_nxt  = rd_idx != REG_ZERO;
        end
        CJSB_OP_JUMP_IND: begin
          // sealed source moved by offset or low bit loses its tag here
          t = cjsb_addr_set(s1_c, s1_c.addr + off_ind);
          t = cjsb_addr_set(t, {t.addr[XLEN-1:1], 1'b0});
          // an entry-sealed target is unsealed, any other sealed type loses its tag
          if (t.ct == CT_ENTRY) begin
            t.ct = CT_NONE;
          end else if (t.ct != CT_NONE) begin
            t.tag = 1'b0;
          end
          npc_nxt    = t;
          npc_wr_nxt = 1'b1;
          lk         = cjsb_addr_set(pc_c, pc_c.addr + ins_width);
          if (ENTRY_EXT) begin
            lk.ct = CT_ENTRY;
          end
          rd_nxt    = lk;
          rd_wr_nxt = rd_idx != REG_ZERO;
        end
        CJSB_OP_BR_EQ, CJSB_OP_BR_NE: begin
          if (rs1_idx >= rs2_idx) begin
            rsv_nxt = 1'b1;
          end else if ((s1_c.addr == s2_c.addr) == (req_op == CJSB_OP_BR_EQ)) begin
            t          = cjsb_addr_set(pc_c, pc_c.addr + off_br);
            npc_nxt    = t;
            npc_wr_nxt = 1'b1;
            // fault is flagged for the fetch, the branch itself retires
            ff_nxt = (t.addr < t.base) || (t.addr >= t.top);
          end
        end
        CJSB_OP_SEAL: begin
          rd_nxt     = s1_c;
          rd_nxt.ct  = cjsb_ambient(s1_c.perm);
          rd_nxt.tag = s1_c.tag && !cjsb_sealed(s1_c);
          rd_wr_nxt  = rd_idx != REG_ZERO;
        end
        CJSB_OP_BUILD: begin
          rd_nxt = s2_c;
          if (s2_c.ct != CT_NONE && s2_c.ct != cjsb_ambient(s2_c.perm)) begin
            rd_nxt.ct = CT_NONE;
          end
          ok = s1_c.tag && !cjsb_sealed(s1_c) && cjsb_intact(s1_c) &&
               cjsb_intact(s2_c) &&
               ((s2_c.perm & ~s1_c.perm) == '0) &&
               (s2_c.base >= s1_c.base) && (s2_c.top <= s1_c.top);
          rd_nxt.tag = ok && (rs1_idx != REG_ZERO);
          rd_wr_nxt  = rd_idx != REG_ZERO;
        end
        default: begin
          done_nxt = req_valid;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output registers

  cjsb_cap_t rd_r;
  cjsb_cap_t npc_r;
  logic      rd_wr_r;
  logic      npc_wr_r;
  logic      done_r;
  logic      rsv_r;
  logic      ff_r;

  // register every result one cycle after the request
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_r     <= CAP_NULL;
      npc_r    <= CAP_NULL;
      rd_wr_r  <= 1'b0;
      npc_wr_r <= 1'b0;
      done_r   <= 1'b0;
      rsv_r    <= 1'b0;
      ff_r     <= 1'b0;
    end else begin
      rd_r     <= rd_nxt;
      npc_r    <= npc_nxt;
      rd_wr_r  <= rd_wr_nxt;
      npc_wr_r <= npc_wr_nxt;
      done_r   <= done_nxt;
      rsv_r    <= rsv_nxt;
      ff_r     <= ff_nxt;
    end
  end

  // unpack registered capabilities onto the flat ports
  assign rd_wr        = rd_wr_r;
  assign rd_tag       = rd_r.tag;
  assign rd_ct        = rd_r.ct;
  assign rd_perm      = rd_r.perm;
  assign rd_rsv       = rd_r.rsv;
  assign rd_base      = rd_r.base;
  assign rd_top       = rd_r.top;
  assign rd_addr      = rd_r.addr;
  assign npc_wr       = npc_wr_r;
  assign npc_tag      = npc_r.tag;
  assign npc_ct       = npc_r.ct;
  assign npc_perm     = npc_r.perm;
  assign npc_rsv      = npc_r.rsv;
  assign npc_base     = npc_r.base;
  assign npc_top      = npc_r.top;
  assign npc_addr     = npc_r.addr;
  assign done         = done_r;
  assign reserved_enc = rsv_r;
  assign fetch_fault  = ff_r;

endmodule : cjsb_exec

/* cjsb_pkg.sv */
// constants, types and helper functions for the capability jump, seal and build datapath
package cjsb_pkg;

  localparam int          XLEN         = 32;
  localparam int          CT_W         = 4;
  localparam int          PERM_W       = 8;
  localparam int          RSV_W        = 2;
  localparam int          UPPER_SHIFT  = 12;  // encoding may override
  localparam int          PERM_EXEC    = 1;   // execute permission bit position
  localparam logic [CT_W-1:0] CT_NONE  = 4'h0;
  localparam logic [CT_W-1:0] CT_ENTRY = 4'h1;
  localparam logic        ENTRY_EXT    = 1'b1;
  localparam logic [4:0]  REG_ZERO     = 5'h00;
  localparam logic [32:0] REP_SLACK    = 33'h000000800;
  localparam logic [31:0] WIDTH_FULL   = 32'h00000004;
  localparam logic [31:0] WIDTH_SHORT  = 32'h00000002;

  typedef enum logic [2:0] {
    CJSB_OP_UPPER_PC,
    CJSB_OP_JUMP_DIR,
    CJSB_OP_JUMP_IND,
    CJSB_OP_BR_EQ,
    CJSB_OP_BR_NE,
    CJSB_OP_SEAL,
    CJSB_OP_BUILD
  } cjsb_op_t;

  typedef struct packed {
    logic              tag;
    logic [CT_W-1:0]   ct;
    logic [PERM_W-1:0] perm;
    logic [RSV_W-1:0]  rsv;
    logic [XLEN-1:0]   base;
    logic [XLEN-1:0]   top;
    logic [XLEN-1:0]   addr;
  } cjsb_cap_t;

  localparam cjsb_cap_t CAP_NULL = '0;

  function automatic logic cjsb_sealed(input cjsb_cap_t c);
    return c.ct != CT_NONE;
  endfunction : cjsb_sealed

  // representable window reaches a fixed slack past each bound
  function automatic logic cjsb_rep_ok(input cjsb_cap_t c, input logic [XLEN-1:0] a);
    return ({1'b0, a} + REP_SLACK >= {1'b0, c.base}) &&
           ({1'b0, a} <= {1'b0, c.top} + REP_SLACK);
  endfunction : cjsb_rep_ok

  function automatic logic cjsb_intact(input cjsb_cap_t c);
    return (c.rsv == '0) && (c.base <= c.top);
  endfunction : cjsb_intact

  // ambient type for a permission set: executable gets the entry type
  function automatic logic [CT_W-1:0] cjsb_ambient(input logic [PERM_W-1:0] p);
    return p[PERM_EXEC] ? CT_ENTRY : CT_NONE;
  endfunction : cjsb_ambient

  // address replacement with tag loss on unrepresentable or sealed move
  function automatic cjsb_cap_t cjsb_addr_set(input cjsb_cap_t c, input logic [XLEN-1:0] a);
    cjsb_cap_t r;
    r = c;
    r.addr = a;
    r.tag = c.tag && cjsb_rep_ok(c, a) && !(cjsb_sealed(c) && a != c.addr);
    return r;
  endfunction : cjsb_addr_set

endpackage : cjsb_pkg

/* cjsb_exec_props.sv */
// assertion checker for the capability jump, seal and build datapath
`timescale 1ns/1ps
module cjsb_exec_props
  import cjsb_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_b,
  // request
  input wire logic              req_valid,
  input wire cjsb_op_t          req_op,
  input wire logic [4:0]        rd_idx,
  input wire logic [4:0]        rs1_idx,
  input wire logic [4:0]        rs2_idx,
  input wire logic [CT_W-1:0]   s1_ct,
  input wire logic [PERM_W-1:0] s1_perm,
  // results
  input wire logic              rd_wr,
  input wire logic              rd_tag,
  input wire logic              npc_wr,
  input wire logic              done,
  input wire logic              reserved_enc,
  input wire logic              fetch_fault,
  input wire logic [CT_W-1:0]   rd_ct,
  input wire logic [XLEN-1:0]   npc_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // single-cycle request kinds shared by several checks
  sequence s_ind;
    req_valid && req_op == CJSB_OP_JUMP_IND;
  endsequence
  sequence s_seal;
    req_valid && req_op == CJSB_OP_SEAL;
  endsequence
  AST_DONE: assert property (req_valid |=> done)
    else $error("done missing after request");
  AST_IDLE: assert property (!req_valid |=> !done)
    else $error("done without request");
  AST_RSV: assert property (req_valid && req_op inside {CJSB_OP_BR_EQ, CJSB_OP_BR_NE}
    && rs1_idx >= rs2_idx |=> reserved_enc && !npc_wr && !rd_wr) else $error("reserved branch");
  AST_IND_BIT0: assert property (s_ind |=> npc_wr && !npc_addr[0])
    else $error("indirect target bit zero set");
  AST_IND_LINK: assert property (s_ind ##0 rd_idx != REG_ZERO |=> rd_wr && rd_ct == CT_ENTRY)
    else $error("return capability not entry sealed");
  AST_IND_NOLINK: assert property (s_ind ##0 rd_idx == REG_ZERO |=> !rd_wr)
    else $error("link written to zero register");
  AST_SEAL_TAG: assert property (s_seal ##0 s1_ct != CT_NONE |=> !rd_tag)
    else $error("sealed source kept tag");
  AST_SEAL_CT: assert property (s_seal ##0 s1_perm[PERM_EXEC] |=> rd_ct == CT_ENTRY)
    else $error("ambient type wrong");
  AST_BLD_ZERO: assert property (req_valid && req_op == CJSB_OP_BUILD && rs1_idx == REG_ZERO
    |=> !rd_tag) else $error("zero authority gave tag");
  AST_FAULT: assert property (fetch_fault |-> npc_wr)
    else $error("fetch fault without pc write");
endmodule : cjsb_exec_props

/* capability_jump_seal_build_tb.sv */
// self-checking testbench for the capability jump, seal and build datapath
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module capability_jump_seal_build_tb;
  import cjsb_pkg::*;
  logic       mclk = 0, rst_b = 0, req_valid = 0, instr_short = 0;
  logic       rd_wr, npc_wr, done, reserved_enc, fetch_fault;
  logic [4:0] rd_idx = 0, rs1_idx = 0, rs2_idx = 0;
  logic [19:0] imm = 0;
  cjsb_op_t   req_op = CJSB_OP_UPPER_PC;
  cjsb_cap_t  pc = '0, s1 = '0, s2 = '0, rd, np;
  cjsb_cap_t  P, N, S, D;
  int         num_errors = 0, checks_done = 0;
  cjsb_exec dut_u (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
    .rd_idx(rd_idx), .rs1_idx(rs1_idx), .rs2_idx(rs2_idx), .imm(imm), .instr_short(instr_short),
    .pc_tag(pc.tag), .pc_ct(pc.ct), .pc_perm(pc.perm), .pc_rsv(pc.rsv), .pc_base(pc.base),
    .pc_top(pc.top), .pc_addr(pc.addr), .s1_tag(s1.tag), .s1_ct(s1.ct), .s1_perm(s1.perm),
    .s1_rsv(s1.rsv), .s1_base(s1.base), .s1_top(s1.top), .s1_addr(s1.addr), .s2_tag(s2.tag),
    .s2_ct(s2.ct), .s2_perm(s2.perm), .s2_rsv(s2.rsv), .s2_base(s2.base), .s2_top(s2.top),
    .s2_addr(s2.addr), .rd_wr(rd_wr), .rd_tag(rd.tag), .rd_ct(rd.ct), .rd_perm(rd.perm),
    .rd_rsv(rd.rsv), .rd_base(rd.base), .rd_top(rd.top), .rd_addr(rd.addr), .npc_wr(npc_wr),
    .npc_tag(np.tag), .npc_ct(np.ct), .npc_perm(np.perm), .npc_rsv(np.rsv),
    .npc_base(np.base), .npc_top(np.top), .npc_addr(np.addr), .done(done),
    .reserved_enc(reserved_enc), .fetch_fault(fetch_fault));
  // clock generation
  initial begin
    forever #25 mclk = ~mclk;
  end
  function automatic cjsb_cap_t mk(logic t, logic [3:0] c, logic [7:0] p, logic [31:0] a);
    return '{t, c, p, 2'h0, 32'h1000, 32'h9000, a};
  endfunction : mk
  // one request, result sampled after the answering edge
  task automatic go(cjsb_op_t o, logic [4:0] d, a, b, logic [19:0] i, cjsb_cap_t p, x, y);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= o;
    rd_idx <= d;
    rs1_idx <= a;
    rs2_idx <= b;
    imm <= i;
    pc <= p;
    s1 <= x;
    s2 <= y;
    @(posedge mclk);
    req_valid <= 1'b0;
    #1;
    `CHK(done, 1'b1)
  endtask : go
  task automatic t_upper();
    go(CJSB_OP_UPPER_PC, 1, 0, 0, 20'h00003, P, N, N);
    `CHK(rd.addr, 32'h5000)
    `CHK(rd.tag, 1'b1)
    `CHK(rd_wr, 1'b1)
    `CHK(rd.perm, 8'hFF)
    `CHK(rd.base, 32'h1000)
    `CHK(rd.top, 32'h9000)
    go(CJSB_OP_UPPER_PC, 1, 0, 0, 20'h00010, P, N, N);
    `CHK(rd.tag, 1'b0)
    go(CJSB_OP_JUMP_DIR, 1, 0, 0, 20'h00010, P, N, N);
    `CHK(np.addr, 32'h2020)
    `CHK(rd.addr, 32'h2004)
    `CHK(rd.ct, CT_ENTRY)
    `CHK(np.tag, 1'b1)
    `CHK(npc_wr, 1'b1)
    go(CJSB_OP_JUMP_DIR, 1, 0, 0, 20'h08000, P, N, N);
    `CHK(np.addr, 32'h12000)
    `CHK(np.tag, 1'b0)
    @(posedge mclk) instr_short <= 1'b1;
    go(CJSB_OP_JUMP_DIR, 1, 0, 0, 20'h00010, P, N, N);
    `CHK(rd.addr, 32'h2002)
    @(posedge mclk) instr_short <= 1'b0;
    $display("upper and direct jump done");
  endtask : t_upper
  task automatic t_ind();
    go(CJSB_OP_JUMP_IND, 1, 5, 0, 20'h0, P, S, N);
    `CHK(np.tag, 1'b1)
    `CHK(np.ct, CT_NONE)
    `CHK(rd.addr, 32'h2004)
    `CHK(rd_wr, 1'b1)
    `CHK(rd.ct, 4'h1)
    `CHK(np.base, 32'h1000)
    `CHK(np.top, 32'h9000)
    `CHK(np.perm, 8'h02)
    go(CJSB_OP_JUMP_IND, 0, 5, 0, 20'h4, P, S, N);
    `CHK(np.tag, 1'b0)
    `CHK(rd_wr, 1'b0)
    go(CJSB_OP_JUMP_IND, 1, 5, 0, 20'h0, P, mk(1, 4'h3, 8'h02, 32'h3000), N);
    `CHK(np.tag, 1'b0)
    go(CJSB_OP_JUMP_IND, 1, 5, 0, 20'h010, P, mk(1, 4'h0, 8'h02, 32'h3001), N);
    `CHK(np.addr, 32'h3010)
    `CHK(np.tag, 1'b1)
    $display("indirect jump done");
  endtask : t_ind
  task automatic t_br();
    S = mk(1, 4'h0, 8'hFF, 32'h8FF0);
    go(CJSB_OP_BR_EQ, 0, 1, 2, 20'h008, S, N, N);
    `CHK(np.addr, 32'h9000)
    `CHK(fetch_fault, 1'b1)
    `CHK(npc_wr, 1'b1)
    `CHK(np.top, 32'h9000)
    go(CJSB_OP_BR_EQ, 0, 1, 2, 20'h004, S, N, N);
    `CHK(fetch_fault, 1'b0)
    go(CJSB_OP_BR_NE, 0, 1, 2, 20'h004, S, N, N);
    `CHK(npc_wr, 1'b0)
    go(CJSB_OP_BR_NE, 0, 1, 2, 20'h004, S, N, P);
    `CHK(npc_wr, 1'b1)
    `CHK(np.addr, 32'h8FF8)
    `CHK(fetch_fault, 1'b0)
    go(CJSB_OP_BR_EQ, 0, 2, 2, 20'h004, S, N, N);
    `CHK(reserved_enc, 1'b1)
    go(CJSB_OP_BR_NE, 0, 3, 1, 20'h004, S, N, N);
    `CHK(reserved_enc, 1'b1)
    `CHK(npc_wr, 1'b0)
    $display("branch done");
  endtask : t_br
  task automatic t_seal();
    go(CJSB_OP_SEAL, 1, 5, 0, 20'h0, P, mk(1, 4'h0, 8'h02, 32'h3000), N);
    `CHK(rd.ct, CT_ENTRY)
    `CHK(rd.ct, 4'h1)
    `CHK(rd.tag, 1'b1)
    go(CJSB_OP_SEAL, 1, 5, 0, 20'h0, P, mk(1, 4'h0, 8'h01, 32'h3000), N);
    `CHK(rd.ct, CT_NONE)
    go(CJSB_OP_SEAL, 1, 5, 0, 20'h0, P, mk(1, 4'h1, 8'h02, 32'h3000), N);
    `CHK(rd.tag, 1'b0)
    D = '{1'b0, 4'h5, 8'h03, 2'h0, 32'h2000, 32'h3000, 32'h2100};
    go(CJSB_OP_BUILD, 1, 5, 6, 20'h0, P, P, D);
    `CHK(rd.tag, 1'b1)
    `CHK(rd.ct, CT_NONE)
    `CHK(rd.addr, 32'h2100)
    `CHK(rd.perm, 8'h03)
    `CHK(rd.top, 32'h3000)
    go(CJSB_OP_BUILD, 1, 0, 6, 20'h0, P, P, D);
    `CHK(rd.tag, 1'b0)
    D.rsv = 2'h1;
    go(CJSB_OP_BUILD, 1, 5, 6, 20'h0, P, P, D);
    `CHK(rd.tag, 1'b0)
    `CHK(rd.rsv, 2'h1)
    D.rsv = 2'h0;
    D.top = 32'hA000;
    go(CJSB_OP_BUILD, 1, 5, 6, 20'h0, P, P, D);
    `CHK(rd.tag, 1'b0)
    $display("seal and build done");
  endtask : t_seal
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // main sequence
  initial begin
    P = mk(1, 4'h0, 8'hFF, 32'h2000);
    N = '0;
    S = mk(1, 4'h1, 8'h02, 32'h3000);
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_upper();
    t_ind();
    t_br();
    t_seal();
    results();
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge mclk);
    num_errors++;
    results();
  end
endmodule : capability_jump_seal_build_tb
bind cjsb_exec cjsb_exec_props u_chk (.*);
